// ===== hdl/decade_timer.sv
`timescale 1ns/1ps
// What this block does
// - Standard one-shot: trigger falling edge sets core, output high, drain released.
// - Standard mode: upper trip clears core, output low, drain turned on.
// - Timer reset pin low forces output low at once and aborts the cycle.
// - Config bit selects standard or low-supply comparator trip levels.
// - Three-bit field selects division factor ten to one million in decades.
// - Extended one-shot: trigger fall enables oscillator and counter, output high.
// - Extended one-shot ends, output low, at terminal count of selected factor.
// - Extended one-shot pulse spans factor rising edges of the oscillator, the first at its start.
// - Extended mode: core free-runs from capacitor comparators and clocks the counter.
// - Factor of one bypasses the counter; core flip-flop drives output directly.
// - Standard mode: capacitor lower trip is ignored; only a trigger fall sets core, output high.
// - Free-running: reset low forces output low and stops oscillation.
// - Extended free-running output frequency is oscillator divided by factor.
// - Extended free-running oscillator runs only with reset high and trigger low.
// - Each decade is divide-by-five then divide-by-two, giving 50% duty.
// - Configuration resets to all zeros: bypass, normal power, standard levels.
// - Low-supply trip select lives in configuration bit five.
module decade_timer (
  // Clock and reset
  input wire logic I_CLK_SYS,
  input wire logic I_NRST,
  // APB slave
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [decade_timer_pkg::ADDR_W-1:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  input wire logic [3:0] I_PSTRB,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  // Timer pins and comparator levels
  input wire logic I_TRIG_N,
  input wire logic I_TMR_RESET_N,
  input wire logic I_CAP_LOW,
  input wire logic I_CAP_HIGH,
  // Timer output and open-drain capacitor drain
  output logic O_TIMER_OUT,
  output logic O_DIS_OUT,
  output logic O_DIS_OE,
  // Analog trims
  output logic O_TRIP_LOW_SUPPLY,
  output logic O_LOW_POWER
);
  import decade_timer_pkg::*;

  localparam int STG_IDX_W = 3;

  // APB state
  cfg_t cfg_r;
  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;

  // Timer state
  logic [1:0] rst_sync_r;
  logic rst_tmr_n;
  logic [SYNC_W-1:0] sync1_r;
  logic [SYNC_W-1:0] sync2_r;
  logic trig_prev_r;
  logic core_r;
  logic core_d_r;
  logic active_r;
  logic out_r;
  logic dis_oe_r;
  logic dis_out_r;
  logic [2:0] cnt_r [STAGES];
  logic [STAGES-1:0] half_r;

  // Decoded control
  wire logic ep_mode;
  wire logic ep_one_shot;
  wire logic [STG_IDX_W-1:0] sel_idx;
  wire logic trig_low;
  wire logic trig_fall;
  wire logic cap_low;
  wire logic cap_high;
  wire logic osc_en;
  wire logic tick0;
  wire logic term;
  wire logic cnt_clr;
  wire logic core_nxt;
  wire logic active_nxt;
  wire logic out_nxt;
  wire logic [STAGES-1:0] tick_in;
  wire logic [STAGES-1:0] carry;
  wire logic [STAGES-1:0] half_nxt;
  wire logic [2:0] cnt_nxt [STAGES];
  wire logic [4*STAGES-1:0] digits;

  // Bypass for codes 0 and 7
  assign ep_mode = (cfg_r.div_sel >= DIV_CODE_FIRST) && (cfg_r.div_sel <= DIV_CODE_LAST);
  assign ep_one_shot = ep_mode & cfg_r.one_shot;
  assign sel_idx = ep_mode ? (cfg_r.div_sel - DIV_CODE_FIRST) : '0;

  // Synchronised pin levels
  assign trig_low = ~sync2_r[SYNC_TRIG];
  assign trig_fall = trig_prev_r & ~sync2_r[SYNC_TRIG];
  assign cap_low = sync2_r[SYNC_CAP_LOW];
  assign cap_high = sync2_r[SYNC_CAP_HIGH];

  // Oscillator gating in extended mode
  assign osc_en = ep_mode & (cfg_r.one_shot ? active_r : trig_low);
  assign cnt_clr = ~osc_en;

  // Decade chain is clocked by rising edges of the free-running core
  assign tick0 = ep_mode & core_r & ~core_d_r;

  genvar g;
  generate
    for (g = 0; g < STAGES; g++) begin : g_stage
      if (g == 0) begin : g_first
        assign tick_in[g] = tick0;
      end else begin : g_next
        assign tick_in[g] = carry[g-1];
      end
      // Divide by five, then divide by two for square output
      assign carry[g] = tick_in[g] & (cnt_r[g] == DIV5_LAST) & half_r[g];
      assign cnt_nxt[g] = cnt_clr ? 3'h0 :
                          !tick_in[g] ? cnt_r[g] :
                          (cnt_r[g] == DIV5_LAST) ? 3'h0 : cnt_r[g] + 3'h1;
      assign half_nxt[g] = cnt_clr ? 1'b0 :
                           (tick_in[g] && (cnt_r[g] == DIV5_LAST)) ? ~half_r[g] : half_r[g];
      assign digits[4*g +: 4] = (half_r[g] ? HALF_WEIGHT : 4'h0) + {1'b0, cnt_r[g]};
      always_ff @(posedge I_CLK_SYS or negedge rst_tmr_n) begin
        if (!rst_tmr_n) begin
          cnt_r[g] <= 3'h0;
          half_r[g] <= 1'b0;
        end else begin
          cnt_r[g] <= cnt_nxt[g];
          half_r[g] <= half_nxt[g];
        end
      end
    end
  endgenerate

  // Carry out of the selected stage is a full count of the factor
  assign term = ep_one_shot & carry[sel_idx];

  // Core flip-flop: trigger wins over threshold, as in a classic timer
  assign core_nxt = !ep_mode ? (trig_fall ? 1'b1 : (cap_high ? 1'b0 : core_r)) :
                    !osc_en ? 1'b0 :
                    cap_low ? 1'b1 :
                    cap_high ? 1'b0 : core_r;

  // Retrigger during an extended pulse is ignored
  assign active_nxt = !ep_one_shot ? 1'b0 :
                      active_r ? ~term : trig_fall;

  assign out_nxt = !ep_mode ? core_nxt :
                   cfg_r.one_shot ? active_nxt :
                   (osc_en & half_r[sel_idx]);

  // Timer reset asserts at once but releases through two flops
  always_ff @(posedge I_CLK_SYS or negedge I_NRST or negedge I_TMR_RESET_N) begin
    if (!I_NRST || !I_TMR_RESET_N) begin
      rst_sync_r <= 2'b00;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_tmr_n = rst_sync_r[1];

  always_ff @(posedge I_CLK_SYS or negedge rst_tmr_n) begin
    if (!rst_tmr_n) begin
      sync1_r <= SYNC_RESET;
      sync2_r <= SYNC_RESET;
      trig_prev_r <= 1'b1;
    end else begin
      sync1_r <= {I_CAP_HIGH, I_CAP_LOW, I_TRIG_N};
      sync2_r <= sync1_r;
      trig_prev_r <= sync2_r[SYNC_TRIG];
    end
  end

  // Output flops clear asynchronously so a timer reset needs no clock
  always_ff @(posedge I_CLK_SYS or negedge rst_tmr_n) begin
    if (!rst_tmr_n) begin
      core_r <= 1'b0;
      core_d_r <= 1'b0;
      active_r <= 1'b0;
      out_r <= 1'b0;
      dis_oe_r <= DIS_OE_RESET;
      dis_out_r <= 1'b0;
    end else begin
      core_r <= core_nxt;
      core_d_r <= core_r;
      active_r <= active_nxt;
      out_r <= out_nxt;
      dis_oe_r <= ~core_nxt;
      dis_out_r <= 1'b0;
    end
  end

  // APB decode; registered ready gives one wait-free access phase
  wire logic setup_ph;
  wire logic wr_en;
  wire logic hit_cfg;
  wire logic hit_status;
  wire logic hit_digits;
  wire logic hit_any;
  wire status_t status_now;
  wire logic [31:0] rdata_nxt;
  wire cfg_t cfg_nxt;

  assign setup_ph = I_PSEL & ~I_PENABLE;
  assign wr_en = I_PSEL & I_PENABLE & pready_r & I_PWRITE;
  assign hit_cfg = (I_PADDR == CFG_OFFSET);
  assign hit_status = (I_PADDR == STATUS_OFFSET);
  assign hit_digits = (I_PADDR == DIGITS_OFFSET);
  assign hit_any = hit_cfg | hit_status | hit_digits;

  assign status_now = '{rsvd: 4'h0, osc_run: osc_en, cycle_active: active_r,
                        core_ff: core_r, timer_out: out_r};
  assign rdata_nxt = hit_cfg ? {24'h000000, cfg_r} :
                     hit_status ? {24'h000000, status_now} :
                     hit_digits ? {8'h00, digits} : 32'h00000000;
  // Upper configuration bits are reserved and always read zero
  assign cfg_nxt = (wr_en && hit_cfg && I_PSTRB[0]) ?
                   cfg_t'({2'b00, I_PWDATA[CFG_W-3:0]}) : cfg_r;

  always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      cfg_r <= cfg_t'(CFG_RESET);
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h00000000;
    end else begin
      cfg_r <= cfg_nxt;
      pready_r <= setup_ph;
      pslverr_r <= setup_ph & ~hit_any;
      prdata_r <= (setup_ph && !I_PWRITE) ? rdata_nxt : 32'h00000000;
    end
  end

  assign O_PRDATA = prdata_r;
  assign O_PREADY = pready_r;
  assign O_PSLVERR = pslverr_r;
  assign O_TIMER_OUT = out_r;
  assign O_DIS_OUT = dis_out_r;
  assign O_DIS_OE = dis_oe_r;
  assign O_TRIP_LOW_SUPPLY = cfg_r.low_supply;
  assign O_LOW_POWER = cfg_r.low_power;

endmodule // decade_timer

// ===== include/decade_timer_pkg.sv
package decade_timer_pkg;

  // APB register map, byte addresses
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] CFG_OFFSET = 8'h00;
  localparam logic [ADDR_W-1:0] STATUS_OFFSET = 8'h04;
  localparam logic [ADDR_W-1:0] DIGITS_OFFSET = 8'h08;

  // Configuration byte
  localparam int CFG_W = 8;
  localparam int CFG_DIV_LSB = 0;
  localparam int CFG_DIV_W = 3;
  localparam int CFG_ONE_SHOT_BIT = 3;
  localparam int CFG_LOW_POWER_BIT = 4;
  localparam int CFG_LOW_SUPPLY_BIT = 5;
  localparam logic [CFG_W-1:0] CFG_RESET = 8'h00;

  // Division codes: 1..6 select a decade, the rest bypass the counter
  localparam logic [CFG_DIV_W-1:0] DIV_CODE_FIRST = 3'h1;
  localparam logic [CFG_DIV_W-1:0] DIV_CODE_LAST = 3'h6;

  // Decade counter shape
  localparam int STAGES = 6;
  localparam logic [2:0] DIV5_LAST = 3'h4;
  localparam logic [3:0] HALF_WEIGHT = 4'h5;

  typedef struct packed {
    logic [1:0] rsvd;
    logic low_supply;
    logic low_power;
    logic one_shot;
    logic [CFG_DIV_W-1:0] div_sel;
  } cfg_t;

  typedef struct packed {
    logic [3:0] rsvd;
    logic osc_run;
    logic cycle_active;
    logic core_ff;
    logic timer_out;
  } status_t;

  // Input synchroniser order and idle levels
  localparam int SYNC_W = 3;
  localparam int SYNC_TRIG = 0;
  localparam int SYNC_CAP_LOW = 1;
  localparam int SYNC_CAP_HIGH = 2;
  localparam logic [SYNC_W-1:0] SYNC_RESET = 3'h1;

  // Drain is on while the core flip-flop is clear, so on during reset
  localparam logic DIS_OE_RESET = 1'b1;

endpackage

// ===== tb/decade_timer_rc.sv
`timescale 1ns/1ps
// Timing capacitor: charges with the drain off, discharges with it on
module decade_timer_rc (
  // Clock and drain
  input wire logic i_clk,
  input wire logic i_dis_oe,
  input wire logic i_slow,
  // Comparator levels
  output logic o_cap_low,
  output logic o_cap_high
);
  logic [3:0] lvl_r = 4'h0;
  logic tick_r = 1'b0;
  always_ff @(posedge i_clk) begin
    tick_r <= !tick_r || !i_slow;
    if (tick_r && i_dis_oe && lvl_r != 4'h0) lvl_r <= lvl_r - 4'h1;
    else if (tick_r && !i_dis_oe && lvl_r != 4'hF) lvl_r <= lvl_r + 4'h1;
  end
  // Wide gap keeps every comparator pulse well over three cycles
  assign o_cap_low = lvl_r < 4'h3;
  assign o_cap_high = lvl_r > 4'hB;
endmodule // decade_timer_rc

// ===== tb/decade_timer_chk.sv
`timescale 1ns/1ps
module decade_timer_chk
  import decade_timer_pkg::*;
(
  // Clock, reset and bus
  input wire logic I_CLK_SYS,
  input wire logic I_NRST,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [decade_timer_pkg::ADDR_W-1:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  input wire logic [3:0] I_PSTRB,
  input wire logic O_PREADY,
  input wire logic O_PSLVERR,
  // Timer pins
  input wire logic I_TRIG_N,
  input wire logic I_TMR_RESET_N,
  input wire logic I_CAP_HIGH,
  input wire logic O_TIMER_OUT,
  input wire logic O_DIS_OE,
  input wire logic O_TRIP_LOW_SUPPLY
);
  cfg_t cfg_r;
  wire logic cfg_wr = I_PSEL && I_PENABLE && O_PREADY && I_PWRITE && I_PSTRB[0]
    && I_PADDR == CFG_OFFSET;
  wire logic byp = cfg_r.div_sel < DIV_CODE_FIRST || cfg_r.div_sel > DIV_CODE_LAST;
  wire logic unmap = !(I_PADDR inside {CFG_OFFSET, STATUS_OFFSET, DIGITS_OFFSET});
  always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) cfg_r <= cfg_t'(CFG_RESET);
    else if (cfg_wr) cfg_r <= cfg_t'(I_PWDATA[7:0]);
  end
  default clocking @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_NRST);
  rst_out_a: assert property (!I_TMR_RESET_N |-> !O_TIMER_OUT && O_DIS_OE)
    else $error("timer reset did not clear output");
  bypass_inv_a: assert property (byp |-> O_TIMER_OUT != O_DIS_OE)
    else $error("bypass output and drain disagree");
  trig_out_a: assert property ((byp || cfg_r.one_shot) && $fell(I_TRIG_N)
    && !O_TIMER_OUT && I_TMR_RESET_N |-> ##[1:6] O_TIMER_OUT)
    else $error("trigger did not start cycle");
  high_clr_a: assert property (byp && $rose(I_CAP_HIGH) && I_TRIG_N
    && I_TMR_RESET_N |-> ##[1:6] !O_TIMER_OUT && O_DIS_OE)
    else $error("upper trip did not end cycle");
  ready_a: assert property (I_PSEL && !I_PENABLE |=> O_PREADY)
    else $error("no ready after setup");
  ready_pulse_a: assert property (O_PREADY |=> !O_PREADY)
    else $error("ready longer than one cycle");
  slverr_a: assert property (O_PREADY |-> O_PSLVERR == unmap)
    else $error("error response wrong for address");
  trip_sel_a: assert property ($stable(cfg_r) |-> O_TRIP_LOW_SUPPLY == cfg_r.low_supply)
    else $error("trip select does not follow config");
  abort_c: cover property ($fell(O_TIMER_OUT) && !I_TMR_RESET_N);
  err_c: cover property (O_PSLVERR);
  ep_end_c: cover property (!byp && $fell(O_TIMER_OUT));
endmodule // decade_timer_chk
bind decade_timer decade_timer_chk decade_timer_chk_i (.I_CLK_SYS, .I_NRST, .I_PSEL,
  .I_PENABLE, .I_PWRITE, .I_PADDR, .I_PWDATA, .I_PSTRB, .O_PREADY, .O_PSLVERR, .I_TRIG_N,
  .I_TMR_RESET_N, .I_CAP_HIGH, .O_TIMER_OUT, .O_DIS_OE, .O_TRIP_LOW_SUPPLY);

// ===== tb/tb_decade_timer.sv
`timescale 1ns/1ps
module tb_decade_timer;
  import decade_timer_pkg::*;
  logic clk = 1'b0, nrst = 1'b0, sel = 1'b0, en = 1'b0, wr = 1'b0, slow = 1'b0;
  logic trg = 1'b1, trst = 1'b1; // Host keeps timer reset high except in the abort test
  logic [7:0] adr = 8'h00;
  logic [31:0] wd = 32'h0, rd, rv;
  logic [3:0] stb = 4'h0;
  logic rdy, slv, ev, cl, ch, tout, doe, lsup, lpw;
  int n_mismatch = 0, checks_done = 0, cyc = 0, k;
  decade_timer decade_timer_i (.I_CLK_SYS(clk), .I_NRST(nrst), .I_PSEL(sel), .I_PENABLE(en),
    .I_PWRITE(wr), .I_PADDR(adr), .I_PWDATA(wd), .I_PSTRB(stb), .O_PRDATA(rd), .O_PREADY(rdy),
    .O_PSLVERR(slv), .I_TRIG_N(trg), .I_TMR_RESET_N(trst), .I_CAP_LOW(cl), .I_CAP_HIGH(ch),
    .O_TIMER_OUT(tout), .O_DIS_OUT(), .O_DIS_OE(doe), .O_TRIP_LOW_SUPPLY(lsup),
    .O_LOW_POWER(lpw));
  decade_timer_rc decade_timer_rc_i (.i_clk(clk), .i_dis_oe(doe), .i_slow(slow),
    .o_cap_low(cl), .o_cap_high(ch));
  initial forever #5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      results();
    end
  end
  task results;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge clk);
    sel <= 1'b1;
    wr <= w;
    adr <= a;
    wd <= d;
    stb <= s;
    @(posedge clk);
    en <= 1'b1;
    // Request held until the edge that samples ready high; answer taken there
    do @(posedge clk); while (rdy !== 1'b1);
    rv = rd;
    ev = slv;
    sel <= 1'b0;
    en <= 1'b0;
  endtask
  task wo(input logic v);
    do @(negedge clk); while (tout !== v);
  endtask
  // Core rising edges seen while the output is high
  task cnt(output int n);
    logic p, h;
    p = doe;
    h = 1'b0;
    n = 0;
    do begin
      @(negedge clk);
      if (p && !doe && (h || tout)) n++;
      p = doe;
      h = h | tout;
    end while (!h || tout);
  endtask
  task t_regs;
    apb(1'b0, CFG_OFFSET, 32'h0, 4'h0);
    chk("cfg_reset", rv, 32'h0);
    chk("trip_reset", lsup, 1'b0);
    apb(1'b1, CFG_OFFSET, 32'hFF, 4'h1);
    apb(1'b1, CFG_OFFSET, 32'h00, 4'h0);
    apb(1'b0, CFG_OFFSET, 32'h0, 4'h0);
    chk("cfg_rw", rv, 32'h3F);
    chk("trip_sel", lsup, 1'b1);
    chk("low_pwr", lpw, 1'b1);
    apb(1'b0, 8'h0C, 32'h0, 4'h0);
    chk("unmapped", ev, 1'b1);
    $display("regs done");
  endtask
  task t_std;
    logic [7:0] sv[3];
    sv = '{8'h00, 8'h08, 8'h0F};
    foreach (sv[i]) begin
      apb(1'b1, CFG_OFFSET, {24'h0, sv[i]}, 4'h1);
      @(posedge clk) trg <= 1'b0;
      wo(1'b1);
      chk("drain_off", doe, 1'b0);
      @(posedge clk) trg <= 1'b1;
      wo(1'b0);
      chk("drain_on", doe, 1'b1);
      repeat (30) @(posedge clk);
    end
    $display("standard one-shot done");
  endtask
  task t_abort;
    @(posedge clk) trg <= 1'b0;
    wo(1'b1);
    @(posedge clk) trst <= 1'b0;
    @(negedge clk) chk("abort_out", tout, 1'b0);
    @(posedge clk) trg <= 1'b1;
    repeat (10) @(posedge clk);
    trst <= 1'b1;
    repeat (40) @(posedge clk);
    chk("aborted", tout, 1'b0);
    $display("abort done");
  endtask
  task t_ep(input logic os);
    for (int c = 1; c <= 2; c++) begin
      slow <= (c == 1);
      apb(1'b1, CFG_OFFSET, {28'h0, os, 3'(c)}, 4'h1);
      @(posedge clk) trg <= 1'b0;
      cnt(k);
      chk("ep_count", k, os ? 10 ** c : 10 ** c / 2);
      @(posedge clk) trg <= 1'b1;
      repeat (60) @(posedge clk);
      chk("ep_stop", {tout, doe}, 2'h1);
    end
    $display("extended mode done");
  endtask
  initial begin
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    repeat (8) @(posedge clk);
    t_regs();
    t_std();
    t_abort();
    t_ep(1'b1);
    t_ep(1'b0);
    results();
  end
endmodule // tb_decade_timer
